// ==== rtl/sfi_irq_regs.sv ====
// Special function register bank: interrupt enables, flags, fetch guard, boot key
// Notes on behaviour
// - Fetch from peripheral space 0h-01FFh or unused space forces a system reset.
// - Conditionally maskable sources: own enable blocks them, global enable does not.
// - Fully nonmaskable sources are delivered regardless of any enable.
// - Boot key word 0AA55h disables the serial boot loader completely.
// - Boot key word zero suppresses mass erase after an invalid password.
// - Vector words 0FFDCh down to 0FFC0h are unused and may hold code.
// - Interrupt and module enable bits sit at the lowest addresses.
// - Unassigned bit positions have no storage and read as zero.
// - Plain reset value bits are read/write and forced by power-up clear.
// - Parenthesised reset value bits are forced only by power-on reset.
// - Enable one at 00h: watchdog 0, oscillator 1, NMI 4, flash violation 5.
// - Watchdog enable acts only in interval timer mode.
// - Enable two at 01h: A receive 0, A transmit 1, B receive 2, B transmit 3.
// - Flags one at 02h: watchdog, oscillator, power-on, external reset, NMI.
// - Watchdog flag sets on watchdog-mode overflow or security key violation.
// - Watchdog flag clears on power-up and on pin reset in reset mode.
// - Power-on flag sets whenever supply powers up.
// - Flags two at 03h: A rx 0, A tx 1, B rx 2, B tx 3.
// - Timer, converter and port flags live in their own modules.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sfi_irq_regs #(
   parameter logic [15:0] RAM_HI = 16'h05FF,
   parameter logic [15:0] FLASH_LO = 16'h8000
) (
   // Clock, resets, enable
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_por_n,
   input wire logic i_ce,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Core status
   input wire logic i_gie,
   input wire logic i_fetch,
   input wire logic [15:0] i_fetch_addr,
   // System events, one-cycle pulses; watchdog interval mode and flash violation flag are levels
   input wire logic i_wdog_ovf,
   input wire logic i_wdog_interval,
   input wire logic i_key_viol,
   input wire logic i_osc_fault,
   input wire logic i_pin_nmi,
   input wire logic i_pin_reset,
   input wire logic i_flash_viol_flag,
   // Serial unit flag sets, one-cycle pulses
   input wire logic [3:0] i_ser_set,
   // Boot loader key
   input wire logic [15:0] i_boot_key,
   input wire logic i_bad_password,
   // Requests to core
   output logic o_sys_reset,
   output logic o_nmi_irq,
   output logic o_wdog_irq,
   output logic o_ser_rx_irq,
   output logic o_ser_tx_irq,
   output logic o_boot_off,
   output logic o_mass_erase
);

   // Inclusive address range check, used by fetch guard
   function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_span = (a >= lo) && (a <= hi);
   endfunction

   // Storage only for assigned bits
   logic [3:0] ie_one_r;
   logic [3:0] ie_one_nxt;
   logic [3:0] ie_two_r;
   logic [3:0] ie_two_nxt;
   logic [3:0] flags_two_r;
   logic [3:0] flags_two_nxt;
   logic osc_flag_r;
   logic osc_flag_nxt;
   logic nmi_flag_r;
   logic nmi_flag_nxt;
   logic wdog_flag_r;
   logic wdog_flag_nxt;
   logic por_flag_r;
   logic por_flag_nxt;
   logic ext_flag_r;
   logic ext_flag_nxt;
   logic [7:0] rdata_nxt;
   logic erase_r;

   // Address decode
   wire logic wr_ie_one = i_wr && (i_addr == sfi_pkg::ADDR_IE_ONE);
   wire logic wr_ie_two = i_wr && (i_addr == sfi_pkg::ADDR_IE_TWO);
   wire logic wr_flags_one = i_wr && (i_addr == sfi_pkg::ADDR_FLAGS_ONE);
   wire logic wr_flags_two = i_wr && (i_addr == sfi_pkg::ADDR_FLAGS_TWO);
   wire logic power_up_clear = !i_rst_n || !i_por_n;

   // Register views, unassigned positions fixed at zero
   wire logic [7:0] ie_one_view = {2'b00, ie_one_r[3:2], 2'b00, ie_one_r[1:0]};
   wire logic [7:0] ie_two_view = {4'h0, ie_two_r};
   wire logic [7:0] flags_one_view = {3'b000, nmi_flag_r, ext_flag_r, por_flag_r, osc_flag_r, wdog_flag_r};
   wire logic [7:0] flags_two_view = {4'h0, flags_two_r};

   // Read mux, unmapped addresses read zero
   always_comb begin
      if (i_addr == sfi_pkg::ADDR_IE_ONE) begin
         rdata_nxt = ie_one_view;
      end else if (i_addr == sfi_pkg::ADDR_IE_TWO) begin
         rdata_nxt = ie_two_view;
      end else if (i_addr == sfi_pkg::ADDR_FLAGS_ONE) begin
         rdata_nxt = flags_one_view;
      end else if (i_addr == sfi_pkg::ADDR_FLAGS_TWO) begin
         rdata_nxt = flags_two_view;
      end else begin
         rdata_nxt = 8'h00;
      end
   end

   // Enable writes pick only the implemented bit positions
   assign ie_one_nxt = wr_ie_one ? {i_wdata[sfi_pkg::BIT_FLASH_EN], i_wdata[sfi_pkg::BIT_NMI_EN],
                                    i_wdata[sfi_pkg::BIT_OSC_EN], i_wdata[sfi_pkg::BIT_WDOG_EN]} : ie_one_r;
   assign ie_two_nxt = wr_ie_two ? i_wdata[3:0] : ie_two_r;

   // Flag next values: hardware set wins over a software write
   assign flags_two_nxt = i_ser_set | (wr_flags_two ? i_wdata[3:0] : flags_two_r);
   assign osc_flag_nxt = i_osc_fault | (wr_flags_one ? i_wdata[sfi_pkg::BIT_OSC_FLAG] : osc_flag_r);
   assign nmi_flag_nxt = i_pin_nmi | (wr_flags_one ? i_wdata[sfi_pkg::BIT_NMI_FLAG] : nmi_flag_r);
   assign ext_flag_nxt = i_pin_reset | (wr_flags_one ? i_wdata[sfi_pkg::BIT_EXT_FLAG] : ext_flag_r);
   assign por_flag_nxt = wr_flags_one ? i_wdata[sfi_pkg::BIT_POR_FLAG] : por_flag_r;

   // Watchdog flag: overflow in watchdog mode or key violation sets, pin reset clears
   wire logic wdog_set = (i_wdog_ovf && !i_wdog_interval) || i_key_viol;
   wire logic wdog_keep = wr_flags_one ? i_wdata[sfi_pkg::BIT_WDOG_FLAG] : wdog_flag_r;
   assign wdog_flag_nxt = wdog_set | (!i_pin_reset && wdog_keep);

   // Bits forced by power-up clear, which power-on reset also implies
   always_ff @(posedge i_clk_sys) begin
      if (power_up_clear) begin
         ie_one_r <= sfi_pkg::RST_IE_ONE;
         ie_two_r <= sfi_pkg::RST_IE_TWO;
         flags_two_r <= sfi_pkg::RST_FLAGS_TWO;
         osc_flag_r <= sfi_pkg::RST_OSC_FLAG;
         nmi_flag_r <= sfi_pkg::RST_NMI_FLAG;
      end else if (i_ce) begin
         ie_one_r <= ie_one_nxt;
         ie_two_r <= ie_two_nxt;
         flags_two_r <= flags_two_nxt;
         osc_flag_r <= osc_flag_nxt;
         nmi_flag_r <= nmi_flag_nxt;
      end
   end

   // Bits forced only by power-on reset; they survive a plain power-up clear
   always_ff @(posedge i_clk_sys) begin
      if (!i_por_n) begin
         wdog_flag_r <= sfi_pkg::RST_WDOG_FLAG;
         por_flag_r <= sfi_pkg::RST_POR_FLAG;
         ext_flag_r <= sfi_pkg::RST_EXT_FLAG;
      end else if (i_ce) begin
         wdog_flag_r <= wdog_flag_nxt;
         por_flag_r <= por_flag_nxt;
         ext_flag_r <= ext_flag_nxt;
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge i_clk_sys) begin
      if (power_up_clear) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= i_rd ? rdata_nxt : 8'h00;
      end
   end

   // Fetch guard: peripheral space plus holes of the map; unused vector words stay legal
   wire logic fetch_periph = in_span(i_fetch_addr, sfi_pkg::PERIPH_LO, sfi_pkg::PERIPH_HI);
   wire logic fetch_ram = in_span(i_fetch_addr, sfi_pkg::RAM_LO, RAM_HI);
   wire logic fetch_boot = in_span(i_fetch_addr, sfi_pkg::BOOT_LO, sfi_pkg::INFO_HI);
   wire logic fetch_flash = (i_fetch_addr >= FLASH_LO);
   wire logic fetch_bad = i_fetch && (fetch_periph || !(fetch_ram || fetch_boot || fetch_flash));

   // Reset class is nonmaskable: no enable gates it
   assign o_sys_reset = fetch_bad || wdog_set;

   // Conditionally maskable group: own enables only, global enable ignored
   wire logic nmi_src = nmi_flag_r && ie_one_r[2];
   wire logic osc_src = osc_flag_r && ie_one_r[1];
   wire logic flash_src = i_flash_viol_flag && ie_one_r[3];
   assign o_nmi_irq = nmi_src || osc_src || flash_src;

   // Maskable sources also need the global enable
   assign o_wdog_irq = i_gie && i_wdog_interval && wdog_flag_r && ie_one_r[0];
   wire logic [3:0] ser_act = flags_two_r & ie_two_r;
   assign o_ser_rx_irq = i_gie && (ser_act[sfi_pkg::BIT_SER_A_RX] || ser_act[sfi_pkg::BIT_SER_B_RX]);
   assign o_ser_tx_irq = i_gie && (ser_act[sfi_pkg::BIT_SER_A_TX] || ser_act[sfi_pkg::BIT_SER_B_TX]);
   // Timer, converter and port flags are kept in their own blocks, none here.

   // Boot key decode; erase pulse is registered so flash control sees a clean strobe
   assign o_boot_off = (i_boot_key == sfi_pkg::KEY_BOOT_OFF);
   wire logic erase_ok = (i_boot_key != sfi_pkg::KEY_NO_ERASE) && !o_boot_off;
   always_ff @(posedge i_clk_sys) begin
      if (power_up_clear) begin
         erase_r <= 1'b0;
      end else if (i_ce) begin
         erase_r <= i_bad_password && erase_ok;
      end
   end
   assign o_mass_erase = erase_r;

   // Checks, disabled while either reset is active
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (power_up_clear);

   sequence s_rd_req;
      i_rd && i_ce && (i_addr == sfi_pkg::ADDR_FLAGS_ONE);
   endsequence
   sequence s_wr_ie_one;
      wr_ie_one && i_ce;
   endsequence

   fetch_guard_a: assert property (i_fetch && (i_fetch_addr <= sfi_pkg::PERIPH_HI) |-> o_sys_reset)
      else $error("peripheral fetch did not reset");
   vec_free_a: assert property (i_fetch && (i_fetch_addr >= sfi_pkg::VEC_FREE_LO)
                                && (i_fetch_addr <= sfi_pkg::VEC_FREE_HI) && !wdog_set |-> !o_sys_reset)
      else $error("free vector fetch caused reset");
   cond_mask_a: assert property (nmi_flag_r && ie_one_r[2] && !i_gie |-> o_nmi_irq)
      else $error("global enable blocked nmi");
   own_en_a: assert property (!ie_one_r[1] && !ie_one_r[2] && !ie_one_r[3] |-> !o_nmi_irq)
      else $error("disabled nmi group asserted");
   boot_key_a: assert property ((i_boot_key == 16'hAA55) == o_boot_off)
      else $error("boot off mismatch");
   no_erase_a: assert property (i_bad_password && i_ce && (i_boot_key == 16'h0000) |=> !o_mass_erase)
      else $error("erase with zero key");
   ie_rd_a: assert property (s_wr_ie_one ##1 (i_rd && i_ce && (i_addr == sfi_pkg::ADDR_IE_ONE))
                             |=> (o_rdata == ($past(i_wdata, 2) & 8'h33)))
      else $error("enable one readback wrong");
   rd_once_a: assert property (s_rd_req ##1 (!i_rd && i_ce) |=> o_rdata == 8'h00)
      else $error("read data stood too long");
   wdog_set_a: assert property (i_ce && i_key_viol |-> o_sys_reset ##1 wdog_flag_r)
      else $error("key violation did not set watchdog flag");
   wdog_clr_a: assert property (i_ce && i_pin_reset && !wdog_set |=> !wdog_flag_r && ext_flag_r)
      else $error("pin reset did not clear watchdog flag");
   wdog_mode_a: assert property (!i_wdog_interval |-> !o_wdog_irq)
      else $error("watchdog irq in watchdog mode");
   ser_gate_a: assert property (i_gie && flags_two_r[0] && ie_two_r[0] |-> o_ser_rx_irq)
      else $error("serial rx request missing");
   set_wins_a: assert property (i_ce && wr_flags_two && !i_wdata[1] && i_ser_set[1] |=> flags_two_r[1])
      else $error("flag set lost against write");

endmodule // sfi_irq_regs
`default_nettype wire

// ==== rtl/sfi_pkg.sv ====
// Constants for the special function interrupt register bank
package sfi_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_IE_ONE = 8'h00;
   localparam logic [7:0] ADDR_IE_TWO = 8'h01;
   localparam logic [7:0] ADDR_FLAGS_ONE = 8'h02;
   localparam logic [7:0] ADDR_FLAGS_TWO = 8'h03;
   // Enable one bit positions
   localparam int BIT_WDOG_EN = 0;
   localparam int BIT_OSC_EN = 1;
   localparam int BIT_NMI_EN = 4;
   localparam int BIT_FLASH_EN = 5;
   // Flags one bit positions
   localparam int BIT_WDOG_FLAG = 0;
   localparam int BIT_OSC_FLAG = 1;
   localparam int BIT_POR_FLAG = 2;
   localparam int BIT_EXT_FLAG = 3;
   localparam int BIT_NMI_FLAG = 4;
   // Serial bits, same positions in enable two and flags two
   localparam int BIT_SER_A_RX = 0;
   localparam int BIT_SER_A_TX = 1;
   localparam int BIT_SER_B_RX = 2;
   localparam int BIT_SER_B_TX = 3;
   // Values after reset
   localparam logic [3:0] RST_IE_ONE = 4'h0;
   localparam logic [3:0] RST_IE_TWO = 4'h0;
   localparam logic [3:0] RST_FLAGS_TWO = 4'hA;
   localparam logic RST_OSC_FLAG = 1'b1;
   localparam logic RST_NMI_FLAG = 1'b0;
   localparam logic RST_WDOG_FLAG = 1'b0;
   localparam logic RST_POR_FLAG = 1'b1;
   localparam logic RST_EXT_FLAG = 1'b0;
   // Boot loader key word values
   localparam logic [15:0] KEY_BOOT_OFF = 16'hAA55;
   localparam logic [15:0] KEY_NO_ERASE = 16'h0000;
   // Address map for fetch checking
   localparam logic [15:0] PERIPH_LO = 16'h0000;
   localparam logic [15:0] PERIPH_HI = 16'h01FF;
   localparam logic [15:0] RAM_LO = 16'h0200;
   localparam logic [15:0] BOOT_LO = 16'h0C00;
   localparam logic [15:0] INFO_HI = 16'h10FF;
   localparam logic [15:0] VEC_FREE_LO = 16'hFFC0;
   localparam logic [15:0] VEC_FREE_HI = 16'hFFDC;
endpackage

// ==== verification/sfi_core_model.sv ====
// CPU core side model driving the register port
`timescale 1ns/10ps
`default_nettype none
module sfi_core_model (
   // Clock and read data
   input wire logic i_clk_sys,
   input wire logic [7:0] i_rdata,
   // Register port
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   // Idle port at time zero
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // One-cycle write; data scrambled after so stale values never look valid
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_rd <= 1'b0;
      @(negedge i_clk_sys);
      d = i_rdata;
   endtask
endmodule // sfi_core_model
`default_nettype wire

// ==== verification/special_function_irq_regs_bench.sv ====
// Self-checking bench for the special function interrupt register bank
`timescale 1ns/10ps
`default_nettype none
module special_function_irq_regs_bench;
   logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, gie = 1'b0, fetch = 1'b0, ovf = 1'b0, intv = 1'b1;
   logic kviol = 1'b0, osc = 1'b0, nmi = 1'b0, pinrst = 1'b0, fviol = 1'b0, badpw = 1'b0;
   logic [15:0] faddr = 16'h0000, key = 16'h1234;
   logic [3:0] sset = 4'h0, en2, fl2;
   logic [7:0] addr, wdata, rdata, got;
   logic wr, rd, sysrst, nmiq, wdq, rxq, txq, bootoff, erase;
   logic [31:0] seed = 32'h311E23EA;
   logic [7:0] exp_por [5] = '{8'h00, 8'h00, 8'h06, 8'h0A, 8'h00};
   logic [7:0] exp_ff [5] = '{8'h33, 8'h0F, 8'h1F, 8'h0F, 8'h00};
   logic [7:0] exp_puc [4] = '{8'h00, 8'h00, 8'h0F, 8'h0A};
   logic [15:0] fa [14] = '{16'h0000, 16'h01FF, 16'h0200, 16'h05FF, 16'h0600, 16'h0BFF, 16'h0C00,
      16'h10FF, 16'h1100, 16'h7FFF, 16'h8000, 16'hFFC0, 16'hFFDC, 16'hFFFE};
   logic [15:0] keys [4] = '{16'hAA55, 16'h0000, 16'h1234, 16'h0001};
   int bad_count = 0;
   int check_count = 0;
   sfi_core_model core (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
   sfi_irq_regs #(.RAM_HI(16'h05FF), .FLASH_LO(16'h8000)) DUT (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_gie(gie), .i_fetch(fetch), .i_fetch_addr(faddr),
      .i_wdog_ovf(ovf), .i_wdog_interval(intv), .i_key_viol(kviol), .i_osc_fault(osc), .i_pin_nmi(nmi),
      .i_pin_reset(pinrst), .i_flash_viol_flag(fviol), .i_ser_set(sset), .i_boot_key(key),
      .i_bad_password(badpw), .o_sys_reset(sysrst), .o_nmi_irq(nmiq), .o_wdog_irq(wdq),
      .o_ser_rx_irq(rxq), .o_ser_tx_irq(txq), .o_boot_off(bootoff), .o_mass_erase(erase));
   // Free-running 200 MHz clock
   initial forever #2.5 clk = ~clk;
   // Repeatable stimulus source
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Fetch is bad outside RAM, boot/info and flash, or inside peripheral space
   function automatic logic bad_f(input logic [15:0] a);
      return a <= sfi_pkg::PERIPH_HI || !((a >= sfi_pkg::RAM_LO && a <= 16'h05FF) ||
         (a >= sfi_pkg::BOOT_LO && a <= sfi_pkg::INFO_HI) || a >= 16'h8000);
   endfunction
   // Serial requests as {tx, rx}
   function automatic logic [1:0] ser_f(input logic [3:0] f, input logic [3:0] e, input logic g);
      logic [3:0] m;
      m = f & e & {4{g}};
      return {m[1] | m[3], m[0] | m[2]};
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         core.rd_reg(8'(i), got);
         chk(got, exp_por[i]);
      end
      for (int i = 0; i < 5; i++) core.wr_reg(8'(i), 8'hFF);
      for (int i = 0; i < 5; i++) begin
         core.rd_reg(8'(i), got);
         chk(got, exp_ff[i]);
      end
      // Power-up clear alone keeps the power-on class bits
      @(posedge clk) rst_n <= 1'b0;
      @(posedge clk) rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         core.rd_reg(8'(i), got);
         chk(got, exp_puc[i]);
      end
      foreach (fa[i]) begin
         @(posedge clk);
         fetch <= 1'b1;
         faddr <= fa[i];
         @(negedge clk) chk(sysrst, bad_f(fa[i]));
      end
      @(posedge clk) fetch <= 1'b0;
      // Conditionally maskable class ignores the global enable, held low here
      core.wr_reg(8'h02, 8'h00);
      @(posedge clk) nmi <= 1'b1;
      @(posedge clk) nmi <= 1'b0;
      @(negedge clk) chk(nmiq, 1'b0);
      core.wr_reg(8'h00, 8'h10);
      @(negedge clk) chk(nmiq, 1'b1);
      core.wr_reg(8'h02, 8'h00);
      fviol <= 1'b1;
      core.wr_reg(8'h00, 8'h20);
      @(negedge clk) chk(nmiq, 1'b1);
      fviol <= 1'b0;
      core.wr_reg(8'h00, 8'h02);
      @(posedge clk) osc <= 1'b1;
      @(posedge clk) osc <= 1'b0;
      @(negedge clk) chk(nmiq, 1'b1);
      // Watchdog overflow in both modes
      core.wr_reg(8'h00, 8'h01);
      gie <= 1'b1;
      @(posedge clk) ovf <= 1'b1;
      @(negedge clk) chk(sysrst, 1'b0);
      @(posedge clk) ovf <= 1'b0;
      intv <= 1'b0;
      @(posedge clk) ovf <= 1'b1;
      @(negedge clk) chk(sysrst, 1'b1);
      @(posedge clk) ovf <= 1'b0;
      @(negedge clk) chk(wdq, 1'b0);
      @(posedge clk) intv <= 1'b1;
      @(negedge clk) chk(wdq, 1'b1);
      // Oscillator flag from the earlier fault pulse is still set
      core.rd_reg(8'h02, got);
      chk(got, 8'h03);
      @(posedge clk) pinrst <= 1'b1;
      @(posedge clk) pinrst <= 1'b0;
      core.rd_reg(8'h02, got);
      chk(got, 8'h0A);
      @(posedge clk) kviol <= 1'b1;
      @(negedge clk) chk(sysrst, 1'b1);
      @(posedge clk) kviol <= 1'b0;
      core.rd_reg(8'h02, got);
      chk(got, 8'h0B);
      // Random serial flags, enables and global enable
      for (int j = 0; j < 6; j++) begin
         seed = xs(seed);
         en2 = seed[3:0];
         fl2 = 4'h0;
         core.wr_reg(8'h01, {4'h0, en2});
         core.wr_reg(8'h03, 8'h00);
         for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            @(posedge clk);
            sset <= seed[3:0] & seed[7:4];
            gie <= seed[8];
            @(posedge clk) sset <= 4'h0;
            fl2 = fl2 | (seed[3:0] & seed[7:4]);
            @(negedge clk) chk({txq, rxq}, ser_f(fl2, en2, gie));
         end
         core.rd_reg(8'h03, got);
         chk(got, {4'h0, fl2});
      end
      // Boot key word decides loader and erase
      foreach (keys[i]) begin
         @(posedge clk);
         key <= keys[i];
         badpw <= 1'b1;
         @(posedge clk) badpw <= 1'b0;
         @(negedge clk) chk({bootoff, erase}, {keys[i] == 16'hAA55, keys[i] != 16'h0 && keys[i] != 16'hAA55});
      end
      tally_and_finish();
   end
endmodule // special_function_irq_regs_bench
`default_nettype wire
